//--- stap_pkg.sv
// Package: register map, field layout and codes of the table access and port-1 PHY block
`default_nettype none
package stap_pkg;

  // ---------------------------------------------------------------
  // Bus and entry widths
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 12;
  localparam int ENTRY_W   = 67;
  localparam int CMD_IDX_W = 10;
  localparam int TOP_W     = 3;

  // ---------------------------------------------------------------
  // Bank bases (byte) and register indexes within a bank
  // ---------------------------------------------------------------
  localparam logic [11:0] TBL_BANK_BASE   = 12'h000;
  localparam logic [11:0] PHY_BANK_BASE   = 12'h100;
  localparam logic [11:0] ALIAS_BANK_BASE = 12'h200;

  localparam logic [7:0] IDX_CMD       = 8'h00;
  localparam logic [7:0] IDX_TOP       = 8'h02;
  localparam logic [7:0] IDX_D47_32    = 8'h04;
  localparam logic [7:0] IDX_D63_48    = 8'h06;
  localparam logic [7:0] IDX_D15_0     = 8'h08;
  localparam logic [7:0] IDX_D31_16    = 8'h0a;
  localparam logic [7:0] IDX_PHY_CTRL  = 8'h00;
  localparam logic [7:0] IDX_ALIAS_CTL = 8'h02;

  // Byte address is bank base plus four times the index
  localparam logic [11:0] ADDR_CMD   = TBL_BANK_BASE + {2'b00, IDX_CMD, 2'b00};
  localparam logic [11:0] ADDR_TOP   = TBL_BANK_BASE + {2'b00, IDX_TOP, 2'b00};
  localparam logic [11:0] ADDR_D0    = TBL_BANK_BASE + {2'b00, IDX_D47_32, 2'b00};
  localparam logic [11:0] ADDR_D1    = TBL_BANK_BASE + {2'b00, IDX_D63_48, 2'b00};
  localparam logic [11:0] ADDR_D2    = TBL_BANK_BASE + {2'b00, IDX_D15_0, 2'b00};
  localparam logic [11:0] ADDR_D3    = TBL_BANK_BASE + {2'b00, IDX_D31_16, 2'b00};
  localparam logic [11:0] ADDR_PHY   = PHY_BANK_BASE + {2'b00, IDX_PHY_CTRL, 2'b00};
  localparam logic [11:0] ADDR_ALIAS = ALIAS_BANK_BASE + {2'b00, IDX_ALIAS_CTL, 2'b00};

  // ---------------------------------------------------------------
  // Command and data fields
  // ---------------------------------------------------------------
  localparam int CMD_DIR_BIT   = 12;
  localparam int CMD_SEL_LSB   = 10;
  localparam int DATA_BUSY_BIT = 7;
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    TBL_STATIC  = 2'b00,
    TBL_VLAN    = 2'b01,
    TBL_DYNAMIC = 2'b10,
    TBL_MIB     = 2'b11
  } stap_table_type;

  // ---------------------------------------------------------------
  // Port-1 PHY control fields
  // ---------------------------------------------------------------
  localparam int PHY_LOOP     = 14;
  localparam int PHY_SPEED    = 13;
  localparam int PHY_AN_EN    = 12;
  localparam int PHY_PDOWN    = 11;
  localparam int PHY_AN_RST   = 9;
  localparam int PHY_DUPLEX   = 8;
  localparam int PHY_XALG     = 5;
  localparam int PHY_XFORCE   = 4;
  localparam int PHY_XOFF     = 3;
  localparam int PHY_FEF_OFF  = 2;
  localparam int PHY_TX_OFF   = 1;
  localparam int PHY_LED_OFF  = 0;
  localparam logic [15:0] PHY_WMASK = 16'h7b3f;
  localparam logic [15:0] PHY_RESET = 16'h1020;

  // Alias register bit for each shared control bit
  localparam int ALIAS_N = 11;
  localparam int PHY_MAP   [ALIAS_N] = '{14, 13, 12, 11, 9, 8, 4, 3, 2, 1, 0};
  localparam int ALIAS_MAP [ALIAS_N] = '{8, 6, 7, 11, 13, 5, 9, 10, 12, 14, 15};

  // ---------------------------------------------------------------
  // Decode codes and bus answers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    REG_CMD   = 4'h0,
    REG_TOP   = 4'h1,
    REG_D0    = 4'h2,
    REG_D1    = 4'h3,
    REG_D2    = 4'h4,
    REG_D3    = 4'h5,
    REG_PHY   = 4'h6,
    REG_ALIAS = 4'h7,
    REG_NONE  = 4'hf
  } stap_reg_type;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

//--- stap_table_engine.sv
// Indirect table access engine: issues one table command and tracks its completion
`default_nettype none
module stap_table_engine #(
  parameter int ENTRY_W = stap_pkg::ENTRY_W,
  parameter int INDEX_W = stap_pkg::CMD_IDX_W
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  // Command from the register file
  input  wire logic                         launch,
  input  wire logic                         cmd_read,
  input  wire stap_pkg::stap_table_type     cmd_sel,
  input  wire logic [INDEX_W-1:0]           cmd_index,
  input  wire logic [ENTRY_W-1:0]           cmd_wdata,
  // Table side
  output logic                              tbl_req_q,
  output logic                              tbl_write_q,
  output stap_pkg::stap_table_type          tbl_sel_q,
  output logic [INDEX_W-1:0]                tbl_index_q,
  output logic [ENTRY_W-1:0]                tbl_wdata_q,
  input  wire logic                         tbl_ack,
  // Status
  output logic                              busy_q,
  output logic                              rd_done
);
  import stap_pkg::*;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_WAIT = 1'b1
  } stap_eng_type;

  stap_eng_type state_q;
  logic         start;

  // Commands arriving while one is pending are dropped
  assign start   = (state_q == ENG_IDLE) && launch;
  assign rd_done = (state_q == ENG_WAIT) && tbl_ack && !tbl_write_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ENG_IDLE;
    end else begin
      unique case (state_q)
        ENG_IDLE: if (launch) state_q <= ENG_WAIT;
        ENG_WAIT: if (tbl_ack) state_q <= ENG_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Table request
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tbl_req_q   <= 1'b0;
      tbl_write_q <= 1'b0;
      tbl_sel_q   <= TBL_STATIC;
      tbl_index_q <= '0;
      tbl_wdata_q <= '0;
    end else if (start) begin
      tbl_req_q   <= 1'b1;
      tbl_write_q <= !cmd_read;
      tbl_sel_q   <= cmd_sel;
      tbl_index_q <= cmd_index;
      tbl_wdata_q <= cmd_wdata;
    end else if (tbl_ack) begin
      tbl_req_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pending flag for dynamic and counter reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= cmd_read && (cmd_sel == TBL_DYNAMIC || cmd_sel == TBL_MIB);
    end else if (rd_done) begin
      busy_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- stap_top.sv
// Register slice: indirect table access and port-1 PHY control behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
module stap_top (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          srst,

  // AXI4-Lite write address
  input  wire logic [stap_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,

  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,

  // AXI4-Lite read address
  input  wire logic [stap_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,

  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,

  // Table access port
  output logic                               tbl_req,
  output logic                               tbl_write,
  output stap_pkg::stap_table_type           tbl_sel,
  output logic [stap_pkg::CMD_IDX_W-1:0]     tbl_index,
  output logic [stap_pkg::ENTRY_W-1:0]       tbl_wdata,
  input  wire logic                          tbl_ack,
  input  wire logic [stap_pkg::ENTRY_W-1:0]  tbl_rdata,

  // Port-1 PHY controls
  output logic                               p1_far_loopback,
  output logic                               p1_force_100,
  output logic                               p1_power_down,
  output logic                               p1_force_full,
  output logic                               p1_crossover_algorithm_select,
  output logic                               p1_force_crossed,
  output logic                               p1_auto_crossover_off,
  output logic                               p1_far_end_fault_off,
  output logic                               p1_transmit_off,
  output logic                               p1_led_off
);
  import stap_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic stap_reg_type decode(input logic [ADDR_W-1:0] a);
    stap_reg_type r;
    r = REG_NONE;

    case (a[ADDR_W-1:2])
      ADDR_CMD[ADDR_W-1:2]:   r = REG_CMD;
      ADDR_TOP[ADDR_W-1:2]:   r = REG_TOP;
      ADDR_D0[ADDR_W-1:2]:    r = REG_D0;
      ADDR_D1[ADDR_W-1:2]:    r = REG_D1;
      ADDR_D2[ADDR_W-1:2]:    r = REG_D2;
      ADDR_D3[ADDR_W-1:2]:    r = REG_D3;
      ADDR_PHY[ADDR_W-1:2]:   r = REG_PHY;
      ADDR_ALIAS[ADDR_W-1:2]: r = REG_ALIAS;
      default:                r = REG_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] m;
    m = old;

    if (strb[0]) m[7:0] = data[7:0];
    if (strb[1]) m[15:8] = data[15:8];
    return m;
  endfunction

  function automatic logic [15:0] phy_to_alias(input logic [15:0] p);
    logic [15:0] a;
    a = 16'h0000;

    for (int i = 0; i < ALIAS_N; i++) begin
      a[ALIAS_MAP[i]] = p[PHY_MAP[i]];
    end
    return a;
  endfunction

  function automatic logic [15:0] alias_to_phy(
    input logic [15:0] p,
    input logic [15:0] a
  );
    logic [15:0] n;
    n = p;

    for (int i = 0; i < ALIAS_N; i++) begin
      n[PHY_MAP[i]] = a[ALIAS_MAP[i]];
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  logic [15:0]       cmd_q;
  logic [TOP_W-1:0]  top_q;
  logic [15:0]       data_q [4];
  logic [15:0]       phy_q;

  logic              busy_q;
  logic              rd_done;

  logic              wr_commit;
  logic              launch;
  stap_reg_type      wr_reg;
  logic [15:0]       cmd_d;
  logic [ENTRY_W-1:0] entry_w;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  // Address and data are taken in either order, then committed together
  assign wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  assign wr_reg    = decode(awaddr_q);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      awaddr_q      <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end else if (wr_commit) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_wready <= 1'b1;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (wr_commit) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  function automatic logic [15:0] rd_value(input stap_reg_type r);
    logic [15:0] v;
    v = 16'h0000;

    case (r)
      REG_CMD:   v = cmd_q;
      REG_TOP:   v = {8'h00, busy_q, 4'h0, top_q};
      REG_D0:    v = data_q[0];
      REG_D1:    v = data_q[1];
      REG_D2:    v = data_q[2];
      REG_D3:    v = data_q[3];
      REG_PHY:   v = phy_q & PHY_WMASK;
      REG_ALIAS: v = phy_to_alias(phy_q);
      default:   v = 16'h0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_value(decode(s_axi_araddr))};
      s_axi_rresp   <= (decode(s_axi_araddr) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Table access command
  // ---------------------------------------------------------------
  assign cmd_d  = merge16(cmd_q, wdata_q, wstrb_q);

  assign launch = wr_commit && (wr_reg == REG_CMD) && (wstrb_q[1:0] != 2'b00);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_q <= CMD_RESET;
    end else if (wr_commit && wr_reg == REG_CMD) begin
      cmd_q <= cmd_d;
    end
  end

  // ---------------------------------------------------------------
  // Entry data registers
  // ---------------------------------------------------------------
  // Register order: 47-32, 63-48, 15-0, 31-16
  assign entry_w = {top_q, data_q[1], data_q[0], data_q[3], data_q[2]};

  // A completing read wins over a host write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        data_q[i] <= DATA_RESET;
      end
    end else if (rd_done) begin
      data_q[0] <= tbl_rdata[47:32];
      data_q[1] <= tbl_rdata[63:48];
      data_q[2] <= tbl_rdata[15:0];
      data_q[3] <= tbl_rdata[31:16];
    end else if (wr_commit) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_reg == stap_reg_type'(4'(REG_D0) + 4'(i))) begin
          data_q[i] <= merge16(data_q[i], wdata_q, wstrb_q);
        end
      end
    end
  end

  // Top entry bits change only from a completed read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      top_q <= '0;
    end else if (rd_done) begin
      top_q <= tbl_rdata[ENTRY_W-1:64];
    end
  end

  stap_table_engine #(
    .ENTRY_W (ENTRY_W),
    .INDEX_W (CMD_IDX_W)
  ) u_engine (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .launch      (launch),
    .cmd_read    (cmd_d[CMD_DIR_BIT]),
    .cmd_sel     (stap_table_type'(cmd_d[CMD_SEL_LSB+:2])),
    .cmd_index   (cmd_d[CMD_IDX_W-1:0]),
    .cmd_wdata   (entry_w),
    .tbl_req_q   (tbl_req),
    .tbl_write_q (tbl_write),
    .tbl_sel_q   (tbl_sel),
    .tbl_index_q (tbl_index),
    .tbl_wdata_q (tbl_wdata),
    .tbl_ack     (tbl_ack),
    .busy_q      (busy_q),
    .rd_done     (rd_done)
  );

  // ---------------------------------------------------------------
  // Port-1 PHY control
  // ---------------------------------------------------------------
  // Both locations write the same flops; each sees the other except bit 5 (PHY_XALG), which only the PHY location holds
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phy_q <= PHY_RESET;
    end else if (wr_commit && wr_reg == REG_PHY) begin
      phy_q <= merge16(phy_q, wdata_q, wstrb_q) & PHY_WMASK;
    end else if (wr_commit && wr_reg == REG_ALIAS) begin
      phy_q <= alias_to_phy(phy_q, merge16(phy_to_alias(phy_q), wdata_q, wstrb_q));
    end
  end

  // Negotiation bits are written and read back only, with no output; port 1 never negotiates
  assign p1_far_loopback               = phy_q[PHY_LOOP];
  assign p1_force_100                  = phy_q[PHY_SPEED];
  assign p1_power_down                 = phy_q[PHY_PDOWN];
  assign p1_force_full                 = phy_q[PHY_DUPLEX];

  assign p1_crossover_algorithm_select = phy_q[PHY_XALG];
  assign p1_force_crossed              = phy_q[PHY_XFORCE];
  assign p1_auto_crossover_off         = phy_q[PHY_XOFF];

  assign p1_far_end_fault_off          = phy_q[PHY_FEF_OFF];
  assign p1_transmit_off               = phy_q[PHY_TX_OFF];
  assign p1_led_off                    = phy_q[PHY_LED_OFF];

endmodule
`default_nettype wire

//--- stap_top_properties.sv
// Checker: bus timing, table command and port-1 control relations
`default_nettype none
module stap_top_properties (
  // Clock and reset
  input wire logic                             clk_sys,
  input wire logic                             srst,
  // Register bus
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_awready,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_wready,
  input wire logic                             s_axi_bvalid,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic [31:0]                      s_axi_rdata,
  input wire logic                             s_axi_rvalid,
  // Table port
  input wire logic                             tbl_req,
  input wire logic                             tbl_write,
  input wire stap_pkg::stap_table_type         tbl_sel,
  input wire logic [stap_pkg::CMD_IDX_W-1:0]   tbl_index,
  input wire logic                             tbl_ack,
  // Port-1 controls
  input wire logic                             p1_far_loopback,
  input wire logic                             p1_force_100,
  input wire logic                             p1_power_down,
  input wire logic                             p1_crossover_algorithm_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import stap_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_commit;
    $rose(s_axi_bvalid);
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_ready_back;
    s_commit |-> s_axi_awready && s_axi_wready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("write slots not freed");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read upper half set");
  property p_launch;
    $rose(tbl_req) |-> s_commit;
  endproperty
  a_launch: assert property (p_launch) else $error("command without write");
  property p_req_hold;
    tbl_req && !tbl_ack |=> tbl_req && $stable(tbl_index) && $stable(tbl_sel) && $stable(tbl_write);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("command changed");
  property p_req_end;
    tbl_req && tbl_ack |=> !tbl_req;
  endproperty
  a_req_end: assert property (p_req_end) else $error("command not retired");
  property p_phy_quiet;
    !$rose(s_axi_bvalid) && !$past(srst)
      |-> $stable({p1_far_loopback, p1_force_100, p1_power_down, p1_crossover_algorithm_select});
  endproperty
  a_phy_quiet: assert property (p_phy_quiet) else $error("control moved");
endmodule
bind stap_top stap_top_properties u_props (.*);
`default_nettype wire

//--- stap_table_model.sv
// Table partner: acknowledges each command after a set delay
`default_nettype none
module stap_table_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Table side of the block
  input  wire logic        tbl_req,
  output logic             tbl_ack,
  output logic [66:0]      tbl_rdata,
  // Bench settings
  input  wire logic [3:0]  delay,
  input  wire logic [66:0] rd_val
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       fire;
  assign fire = tbl_req && !tbl_ack && (cnt_q == delay);
  always_ff @(posedge clk_sys) begin
    if (srst || !tbl_req || tbl_ack) begin
      cnt_q <= 4'h0;
    end else if (!fire) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Entry valid only in the ack cycle
  always_ff @(posedge clk_sys) begin
    tbl_ack   <= fire && !srst;
    tbl_rdata <= srst ? 67'h0 : (fire ? rd_val : ~tbl_rdata);
  end
endmodule
`default_nettype wire

//--- stap_top_tb_top.sv
// Testbench: register traffic, table commands and port-1 controls
`default_nettype none
module stap_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import stap_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tbl_req, tbl_write, tbl_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  stap_table_type tbl_sel;
  logic [9:0] tbl_index, p1_vec;
  logic [66:0] tbl_wdata, tbl_rdata, rd_val = 67'h0;
  logic [3:0] delay = 4'h0;
  logic p1_far_loopback, p1_force_100, p1_power_down, p1_force_full, p1_crossover_algorithm_select;
  logic p1_force_crossed, p1_auto_crossover_off, p1_far_end_fault_off, p1_transmit_off, p1_led_off;
  logic [15:0] seed = 16'h000a;
  logic [76:0] cap;
  int n_errors = 0, cmp_count = 0, n_acks = 0;
  logic [11:0] dad [4] = '{ADDR_D0, ADDR_D1, ADDR_D2, ADDR_D3};
  int lo [4] = '{32, 48, 0, 16};
  stap_top uut (.*);
  stap_table_model u_table (.*);
  always #50 clk_sys = ~clk_sys;
  assign p1_vec = {p1_far_loopback, p1_force_100, p1_power_down, p1_force_full, p1_crossover_algorithm_select,
                   p1_force_crossed, p1_auto_crossover_off, p1_far_end_fault_off, p1_transmit_off, p1_led_off};
  // Record each retired command
  always @(posedge clk_sys) begin
    if (tbl_req && tbl_ack) begin
      cap <= {tbl_write, tbl_sel, tbl_index, tbl_wdata[63:0]};
      n_acks <= n_acks + 1;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] remap(input logic [15:0] v, input logic [15:0] base, input logic fwd);
    logic [15:0] o;
    o = base;
    for (int i = 0; i < ALIAS_N; i++) begin
      if (fwd) o[ALIAS_MAP[i]] = v[PHY_MAP[i]];
      else o[PHY_MAP[i]] = v[ALIAS_MAP[i]];
    end
    return o;
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    $display("MISMATCH t=%0t no answer", $time);
    conclude();
  endtask
  task automatic chk_v(input logic [66:0] g, input logic [66:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t response %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1'b1;
        chk_r(s_axi_bresp, e);
      end
    end
    if (!got) hang();
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    if (!got) hang();
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk_r(r, RESP_OKAY);
    chk_v(67'(d), 67'(e));
  endtask
  task automatic idle;
    for (int n = 0; n < 40 && tbl_req; n++) @(posedge clk_sys);
    if (tbl_req) hang();
    @(posedge clk_sys);
  endtask
  initial begin
    logic [15:0] v, ph;
    logic [31:0] d;
    logic [1:0] r;
    logic [66:0] ent;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rc(ADDR_PHY, PHY_RESET);
    chk_v(67'(p1_vec), 67'(10'h020));
    for (int j = 0; j < 4; j++) rc(dad[j], 16'h0000);
    rc(ADDR_TOP, DATA_RESET);
    $display("test reset done");
    ph = PHY_RESET;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 16'hffff : seed;
      wr(k[0] ? ADDR_ALIAS : ADDR_PHY, v, RESP_OKAY);
      ph = k[0] ? remap(v, ph, 1'b0) : (v & PHY_WMASK);
      rc(ADDR_PHY, ph);
      chk_v(67'(p1_vec), 67'({ph[14], ph[13], ph[11], ph[8], ph[5:0]}));
      rc(ADDR_ALIAS, remap(ph, 16'h0000, 1'b1));
    end
    wr(12'h300, 16'hffff, RESP_SLVERR);
    rdr(12'h300, d, r);
    chk_r(r, RESP_SLVERR);
    chk_v(67'(d), 67'h0);
    wr(ADDR_TOP, 16'hffff, RESP_OKAY);
    rc(ADDR_TOP, 16'h0000);
    $display("test phy done");
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        seed = lfsr(seed);
        ent[lo[j] +: 16] = seed;
        wr(dad[j], seed, RESP_OKAY);
      end
      chk_v(67'(n_acks), 67'(k));
      seed = lfsr(seed);
      delay <= k[1] ? 4'h9 : 4'h0;
      wr(ADDR_CMD, {3'b000, 1'b0, k[1:0], seed[9:0]}, RESP_OKAY);
      idle();
      chk_v(67'(cap[76:64]), 67'({1'b1, k[1:0], seed[9:0]}));
      chk_v(67'(cap[63:0]), 67'(ent[63:0]));
    end
    $display("test table write done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ent = {seed[2:0], seed, ~seed, seed ^ 16'h5a5a, seed[7:0], seed[15:8]};
      rd_val <= ent;
      delay <= k[1] ? 4'hc : 4'h1;
      wr(ADDR_CMD, {3'b000, 1'b1, k[1:0], seed[9:0]}, RESP_OKAY);
      rdr(ADDR_TOP, d, r);
      chk_v(67'(d[7]), 67'(k[1]));
      if (k == 3) wr(ADDR_CMD, 16'h0000, RESP_OKAY);
      for (int n = 0; n < 30 && d[7]; n++) rdr(ADDR_TOP, d, r);
      if (d[7]) hang();
      idle();
      rc(ADDR_TOP, {13'h0000, ent[66:64]});
      for (int j = 0; j < 4; j++) rc(dad[j], ent[lo[j] +: 16]);
      chk_v(67'(cap[76:64]), 67'({1'b0, k[1:0], seed[9:0]}));
    end
    rc(ADDR_CMD, 16'h0000);
    chk_v(67'(n_acks), 67'(8));
    $display("test table read done");
    conclude();
  end
endmodule
`default_nettype wire
